// file: common/bse_pkg.sv
// Constants and types of the belt speed and elevation control core
`default_nettype none
package bse_pkg;
   // System clock and printed times
   localparam int CLK_HZ = 10_000_000;
   localparam int WIN_MS = 2000;         // Speed averaging window
   localparam int ZERO_MS = 2000;        // No motion at lower limit
   localparam int TRIM_MS = 4000;        // Least spacing of PWM trims
   localparam int COMM_MS = 500;         // Host silence before stop
   localparam int PWM_HZ = 4000;
   localparam int WIN_CYC = CLK_HZ / 1000 * WIN_MS;
   localparam int ZERO_CYC = CLK_HZ / 1000 * ZERO_MS;
   localparam int TRIM_CYC = CLK_HZ / 1000 * TRIM_MS;
   localparam int COMM_CYC = CLK_HZ / 1000 * COMM_MS;
   localparam int PWM_CYC = CLK_HZ / PWM_HZ;
   localparam int DEB_CYC = 10_000;      // Elevation switch debounce
   localparam int CNT_W = 27;
   // PWM duty resolution
   localparam int DUTY_W = 10;
   localparam logic [15:0] DUTY_MAX = 16'h03ff;
   // Speeds in hundredths of a mile per hour
   localparam logic [15:0] SPD_TOL = 16'h0032;     // 0.5 MPH
   localparam logic [15:0] SPD_TRIP = 16'h012c;    // 3.0 MPH
   localparam logic [15:0] SPD_DEAD = 16'h0008;    // 0.08 MPH
   localparam logic [15:0] TENTH_TO_HUND = 16'h000a;
   localparam logic [15:0] ELEV_STEP = 16'h0005;   // Half percent steps
   localparam logic [15:0] SPD_MAX_DEF = 16'h0096;
   localparam logic [15:0] ELEV_MAX_DEF = 16'h00fa;
   // Calibration words in nonvolatile memory
   localparam logic [2:0] CAL_PWM = 3'h0;
   localparam logic [2:0] CAL_REED = 3'h1;
   localparam logic [2:0] CAL_MREF = 3'h2;
   localparam logic [2:0] CAL_ELEV = 3'h3;
   localparam logic [2:0] CAL_SUM = 3'h4;
   localparam logic [15:0] CAL_DEAD = 16'h0000;    // Non-operational gain
   localparam int GAIN_SH = 4;                      // Set point gains
   localparam int MEAS_SH = 8;                      // Pulse count gains
   // Register indices
   localparam logic [2:0] REG_CMD = 3'h0;
   localparam logic [2:0] REG_SPD = 3'h1;
   localparam logic [2:0] REG_ELEV = 3'h2;
   localparam logic [2:0] REG_STAT = 3'h3;
   localparam logic [2:0] REG_MEAS0 = 3'h4;
   localparam logic [2:0] REG_MEAS1 = 3'h5;
   localparam logic [2:0] REG_POS = 3'h6;
   localparam logic [2:0] REG_DUTY = 3'h7;
   // Command register bits
   localparam int CMD_START_CS = 0;
   localparam int CMD_START_NC = 1;
   localparam int CMD_STOP = 2;
   // Synchronised pins
   localparam int NPIN = 7;
   localparam int P_REED = 0;
   localparam int P_MREF = 1;
   localparam int P_ESW = 2;
   localparam int P_ESTOP = 3;
   localparam int P_AC = 4;
   localparam int P_MFLT = 5;
   localparam int P_SELF = 6;
   localparam logic [NPIN-1:0] PIN_RST = 7'h00;

   typedef enum logic [7:0] {
      ST_NVM = 8'h01,
      ST_SUSP = 8'h02,
      ST_START = 8'h04,
      ST_SELF = 8'h08,
      ST_ZERO = 8'h10,
      ST_NORESP = 8'h20,
      ST_OPER = 8'h40,
      ST_FAULT = 8'h80
   } bse_state_e;

   // Register port of the core
   typedef struct packed {
      logic [2:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } bse_req_s;

   // Drive outputs toward motor controller and relays
   typedef struct packed {
      logic pwm;
      logic belt_en;
      logic up;
      logic dn;
   } bse_drv_s;
endpackage
`default_nettype wire

// file: verilog/bse_core.sv
// Belt speed and elevation control core of the smart_supply_board
//
// Contract
// - At power-up read calibration words and verify their checksum first.
// - Bad checksum loads dead constants and suspends until recalibrated.
// - Good checksum: startup, self-test check, drive elevation down.
// - Lower limit reached after two seconds without switch motion.
// - Start during zeroing: non-responsive until comm timeout or stop.
// - Zeroing done without start: operational, both set points zero.
// - Operational: drive PWM, belt enable, raise, lower from set points.
// - Check speed and grade set points; adopt only if valid.
// - Measure belt speed from reed switch and motor speed reference.
// - Over-speed, zero-speed or mismatch stops belt and enters the fault state.
// - Elevation by up and down relays, open-loop switch count.
// - Emergency stop or AC loss de-energises every output.
// - Belt enable must be asserted for the belt to run.
// - Speed reference is 4 kHz PWM with 1024 duty counts.
// - Average each speed input over a two second window.
// - Stop belt if input over set by 0.5 MPH or inputs differ.
// - Drop belt enable at once if 3.0 MPH over set point.
// - Motor controller fault shuts the system down immediately.
// - Trim PWM one count when off by 0.08 MPH, once per 4 s.
// - Debounced switch changes count up when raising, down when lowering.
// - Run elevation to target count, then off until new set point.
// - With comm stop enabled, stop belt after 0.5 s host silence.
`timescale 1ns/10ps
`default_nettype none
module bse_core import bse_pkg::*; #(
   parameter int WIN = WIN_CYC,
   parameter int ZERO = ZERO_CYC,
   parameter int TRIM = TRIM_CYC,
   parameter int COMM = COMM_CYC,
   parameter int DEB = DEB_CYC,
   parameter logic [15:0] SPD_MAX = SPD_MAX_DEF,
   parameter logic [15:0] ELEV_MAX = ELEV_MAX_DEF
) (
   input wire logic mclk,                 // System clock
   input wire logic rst_b,                // Asynchronous reset
   input wire bse_req_s req,              // Register request
   output logic [15:0] rdata,             // Read data, cycle after read
   output logic nvm_rd,                   // Calibration word read
   output logic [2:0] nvm_addr,           // Calibration word index
   input wire logic [15:0] nvm_data,      // Calibration word
   input wire logic nvm_ack,              // Calibration word valid
   input wire logic reed_in,              // Belt pulley reed switch
   input wire logic mref_in,              // Motor controller speed pulses
   input wire logic elev_sw_in,           // Elevation gear micro switch
   input wire logic estop_ok_in,          // Emergency stop loop closed
   input wire logic ac_ok_in,             // AC power present
   input wire logic mc_fault_in,          // Motor controller fault
   input wire logic selftest_in,          // Self-test request strap
   output bse_drv_s drv                   // PWM, belt enable, relays
);
   typedef struct packed {
      bse_state_e st;
      logic [NPIN-1:0] s1;
      logic [NPIN-1:0] s2;
      logic [NPIN-1:0] s3;
      logic [NPIN-1:0] lvl;
      logic nvm_rd;
      logic [2:0] nvm_idx;
      logic [15:0] sum;
      logic [15:0] g_pwm;
      logic [1:0][15:0] g_meas;
      logic [15:0] g_elev;
      logic run;
      logic cs_en;
      logic err;
      logic [3:0] flt;
      logic settled;
      logic [15:0] spd_set;
      logic [15:0] elev_set;
      logic [15:0] elev_tgt;
      logic [15:0] elev_pos;
      logic elev_busy;
      logic esw;
      logic [DUTY_W-1:0] duty;
      logic [11:0] pwm_cnt;
      logic [CNT_W-1:0] win;
      logic [CNT_W-1:0] trim;
      logic [CNT_W-1:0] idle;
      logic [CNT_W-1:0] comm;
      logic [CNT_W-1:0] deb;
      logic [1:0][15:0] ecnt;
      logic [1:0][15:0] meas;
      logic [15:0] rdata;
      bse_drv_s drv;
   } bse_reg_s;

   bse_reg_s r_r;
   bse_reg_s r_nxt;
   logic [NPIN-1:0] pin_raw;

   assign pin_raw = {selftest_in, mc_fault_in, ac_ok_in, estop_ok_in,
                     elev_sw_in, mref_in, reed_in};
   assign rdata = r_r.rdata;
   assign nvm_rd = r_r.nvm_rd;
   assign nvm_addr = r_r.nvm_idx;
   assign drv = r_r.drv;

   always_comb begin
      bse_reg_s n;
      logic [NPIN-1:0] edg;
      logic pwr_ok;
      logic esw_chg;
      logic win_end;
      logic [31:0] prod;
      logic [15:0] tgt;
      logic [15:0] avg;
      logic [15:0] diff;
      logic [15:0] dut16;
      logic over_tol;
      logic over_trip;
      logic cmd_start;
      logic cmd_stop;
      logic is_wr;
      n = r_r;
      prod = '0;
      dut16 = '0;
      n.nvm_rd = 1'b0;
      // Three-stage pin capture, change taken when stages two and three agree
      n.s1 = pin_raw;
      n.s2 = r_r.s1;
      n.s3 = r_r.s2;
      for (int i = 0; i < NPIN; i++) begin
         if (r_r.s2[i] == r_r.s3[i]) begin
            n.lvl[i] = r_r.s3[i];
         end
      end
      edg = n.lvl & ~r_r.lvl;
      pwr_ok = r_r.lvl[P_ESTOP] & r_r.lvl[P_AC];
      is_wr = req.wr;
      cmd_start = is_wr && req.addr == REG_CMD &&
                  (req.wdata[CMD_START_CS] || req.wdata[CMD_START_NC]);
      cmd_stop = is_wr && req.addr == REG_CMD && req.wdata[CMD_STOP];
      // Debounce of the elevation switch
      esw_chg = 1'b0;
      if (r_r.lvl[P_ESW] == r_r.esw) begin
         n.deb = '0;
      end else if (r_r.deb >= CNT_W'(DEB - 1)) begin
         n.deb = '0;
         n.esw = r_r.lvl[P_ESW];
         esw_chg = 1'b1;
      end else begin
         n.deb = r_r.deb + 1'b1;
      end
      if (esw_chg && r_r.drv.up) begin
         n.elev_pos = r_r.elev_pos + 16'h0001;
      end else if (esw_chg && r_r.drv.dn) begin
         n.elev_pos = r_r.elev_pos - 16'h0001;
      end
      // Pulse counting and two second averaging window
      win_end = r_r.win >= CNT_W'(WIN - 1);
      n.win = win_end ? '0 : r_r.win + 1'b1;
      for (int c = 0; c < 2; c++) begin
         if (win_end) begin
            prod = 32'(r_r.ecnt[c]) * 32'(r_r.g_meas[c]);
            n.meas[c] = prod[MEAS_SH +: 16];
            n.ecnt[c] = 16'(edg[c]);
         end else if (edg[c]) begin
            n.ecnt[c] = r_r.ecnt[c] + 16'h0001;
         end
      end
      tgt = 16'(r_r.spd_set * TENTH_TO_HUND);
      over_tol = (r_r.meas[0] > tgt + SPD_TOL) ||
                 (r_r.meas[1] > tgt + SPD_TOL);
      over_trip = (r_r.meas[0] > tgt + SPD_TRIP) ||
                  (r_r.meas[1] > tgt + SPD_TRIP);
      diff = (r_r.meas[0] > r_r.meas[1]) ? r_r.meas[0] - r_r.meas[1]
                                         : r_r.meas[1] - r_r.meas[0];
      avg = 16'((17'(r_r.meas[0]) + 17'(r_r.meas[1])) >> 1);
      // PWM period counter
      n.pwm_cnt = (r_r.pwm_cnt >= 12'(PWM_CYC - 1)) ? 12'h000
                                                    : r_r.pwm_cnt + 12'h001;
      if (r_r.trim != '0) begin
         n.trim = r_r.trim - 1'b1;
      end
      n.comm = is_wr ? '0 : r_r.comm + 1'b1;
      if (r_r.comm >= CNT_W'(COMM - 1)) begin
         n.comm = r_r.comm;
      end
      // Register reads; status read clears the refused flag
      if (req.rd) begin
         unique case (req.addr)
            REG_SPD: n.rdata = r_r.spd_set;
            REG_ELEV: n.rdata = r_r.elev_set;
            REG_STAT: n.rdata = {r_r.err, r_r.run, r_r.cs_en, r_r.elev_busy,
                                 r_r.flt, r_r.st};
            REG_MEAS0: n.rdata = r_r.meas[0];
            REG_MEAS1: n.rdata = r_r.meas[1];
            REG_POS: n.rdata = r_r.elev_pos;
            REG_DUTY: n.rdata = 16'(r_r.duty);
            default: n.rdata = 16'h0000;
         endcase
         if (req.addr == REG_STAT) begin
            n.err = 1'b0;
         end
      end
      n.drv.up = 1'b0;
      n.drv.dn = 1'b0;
      unique case (r_r.st)
         ST_NVM: begin
            if (r_r.nvm_idx == CAL_PWM && r_r.sum == 16'h0000 &&
                !r_r.nvm_rd && r_r.win == CNT_W'(1)) begin
               n.nvm_rd = 1'b1;
            end
            if (nvm_ack) begin
               unique case (r_r.nvm_idx)
                  CAL_PWM: n.g_pwm = nvm_data;
                  CAL_REED: n.g_meas[0] = nvm_data;
                  CAL_MREF: n.g_meas[1] = nvm_data;
                  CAL_ELEV: n.g_elev = nvm_data;
                  default: ;
               endcase
               if (r_r.nvm_idx == CAL_SUM) begin
                  if (nvm_data == r_r.sum) begin
                     n.st = ST_START;
                  end else begin
                     n.g_pwm = CAL_DEAD;
                     n.g_meas = '0;
                     n.g_elev = CAL_DEAD;
                     n.st = ST_SUSP;
                  end
               end else begin
                  n.sum = r_r.sum + nvm_data;
                  n.nvm_idx = r_r.nvm_idx + 3'h1;
                  n.nvm_rd = 1'b1;
               end
            end
         end
         ST_SUSP: ;
         ST_START: begin
            n.idle = '0;
            n.st = r_r.lvl[P_SELF] ? ST_SELF : ST_ZERO;
         end
         ST_SELF: ;
         ST_ZERO: begin
            n.drv.dn = 1'b1;
            n.idle = esw_chg ? '0 : r_r.idle + 1'b1;
            if (cmd_start) begin
               n.st = ST_NORESP;
               n.comm = '0;
            end else if (r_r.idle >= CNT_W'(ZERO - 1)) begin
               n.st = ST_OPER;
               n.elev_pos = 16'h0000;
               n.spd_set = 16'h0000;
               n.elev_set = 16'h0000;
               n.elev_tgt = 16'h0000;
               n.elev_busy = 1'b0;
               n.duty = '0;
               n.run = 1'b0;
            end
         end
         ST_NORESP: begin
            if (cmd_stop || r_r.comm >= CNT_W'(COMM - 1)) begin
               n.st = ST_START;
            end
         end
         ST_OPER: begin
            if (cmd_stop) begin
               n.run = 1'b0;
            end else if (cmd_start) begin
               n.run = 1'b1;
               n.cs_en = req.wdata[CMD_START_CS];
               n.settled = 1'b0;
               n.trim = CNT_W'(TRIM);
            end
            if (is_wr && req.addr == REG_SPD) begin
               if (req.wdata <= SPD_MAX) begin
                  n.spd_set = req.wdata;
                  prod = 32'(req.wdata) * 32'(r_r.g_pwm);
                  dut16 = prod[GAIN_SH +: 16];
                  n.duty = DUTY_W'((dut16 > DUTY_MAX) ? DUTY_MAX : dut16);
                  n.settled = 1'b0;
                  n.trim = CNT_W'(TRIM);
               end else begin
                  n.err = 1'b1;
               end
            end
            if (is_wr && req.addr == REG_ELEV) begin
               if (req.wdata <= ELEV_MAX &&
                   req.wdata % ELEV_STEP == 16'h0000) begin
                  n.elev_set = req.wdata;
                  prod = 32'(req.wdata) * 32'(r_r.g_elev);
                  n.elev_tgt = prod[GAIN_SH +: 16];
                  n.elev_busy = 1'b1;
               end else begin
                  n.err = 1'b1;
               end
            end
            if (r_r.run && r_r.cs_en && r_r.comm >= CNT_W'(COMM - 1)) begin
               n.run = 1'b0;
            end
            // Open-loop elevation positioning
            if (r_r.elev_busy) begin
               if (r_r.elev_pos < r_r.elev_tgt) begin
                  n.drv.up = 1'b1;
               end else if (r_r.elev_pos > r_r.elev_tgt) begin
                  n.drv.dn = 1'b1;
               end else begin
                  n.elev_busy = 1'b0;
               end
            end
            // Speed supervision at each window end
            if (r_r.run && win_end) begin
               n.settled = 1'b1;
               if (r_r.settled && over_tol) begin
                  n.flt[0] = 1'b1;
               end
               if (r_r.settled && diff > SPD_TOL) begin
                  n.flt[1] = 1'b1;
               end
               if (r_r.settled && r_r.spd_set != 16'h0000 &&
                   r_r.meas[0] == 16'h0000 && r_r.meas[1] == 16'h0000) begin
                  n.flt[2] = 1'b1;
               end
            end
            if (r_r.run && r_r.settled && !over_tol && diff <= SPD_TOL &&
                r_r.trim == '0 && win_end) begin
               n.trim = CNT_W'(TRIM);
               if (avg > tgt + SPD_DEAD && r_r.duty != '0) begin
                  n.duty = r_r.duty - 1'b1;
               end else if (avg + SPD_DEAD < tgt && r_r.duty != '1) begin
                  n.duty = r_r.duty + 1'b1;
               end
            end
            if (r_r.run && over_trip) begin
               n.flt[0] = 1'b1;
            end
            if (n.flt != 4'h0) begin
               n.st = ST_FAULT;
               n.run = 1'b0;
            end
         end
         ST_FAULT: n.run = 1'b0;
         default: n.st = ST_FAULT;
      endcase
      if (r_r.lvl[P_MFLT] && r_r.st != ST_NVM && r_r.st != ST_SUSP) begin
         n.flt[3] = 1'b1;
         n.st = ST_FAULT;
         n.run = 1'b0;
      end
      if (is_wr && r_r.st != ST_OPER &&
          !(r_r.st == ST_ZERO && cmd_start) &&
          !(r_r.st == ST_NORESP && cmd_stop)) begin
         n.err = 1'b1;
      end
      // Output stage
      n.drv.pwm = r_r.run && (32'(r_r.pwm_cnt) << DUTY_W) <
                  32'(r_r.duty) * 32'(PWM_CYC);
      n.drv.belt_en = n.run && n.st == ST_OPER && !over_trip;
      if (n.st != ST_OPER && n.st != ST_ZERO) begin
         n.drv.up = 1'b0;
         n.drv.dn = 1'b0;
      end
      if (!pwr_ok) begin
         n.run = 1'b0;
         n.drv = '0;
      end
      r_nxt = n;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         r_r <= '{st: ST_NVM, s1: PIN_RST, s2: PIN_RST, s3: PIN_RST,
                  lvl: PIN_RST, nvm_idx: CAL_PWM, g_pwm: CAL_DEAD,
                  g_elev: CAL_DEAD, default: '0};
      end else begin
         r_r <= r_nxt;
      end
   end
endmodule // bse_core
`default_nettype wire

// file: test/bse_core_chk.sv
// Port assertions of the belt speed and elevation control core
`timescale 1ns/10ps
`default_nettype none
module bse_core_chk import bse_pkg::*; (
   input wire logic mclk, // System clock
   input wire logic rst_b, // Reset, active low
   input wire logic nvm_rd, // Word read pulse
   input wire logic [2:0] nvm_addr, // Word index
   input wire logic [15:0] nvm_data, // Word
   input wire logic nvm_ack, // Word valid
   input wire logic estop_ok_in, // Stop loop closed
   input wire logic ac_ok_in, // AC present
   input wire logic mc_fault_in, // Motor controller fault
   input wire logic selftest_in, // Self-test strap
   input wire bse_drv_s drv // Drive outputs
);
   logic [15:0] sum_r;
   // Running sum of the calibration words seen so far
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sum_r <= 16'h0000;
      end else if (nvm_ack && nvm_addr != 3'h4) begin
         sum_r <= sum_r + nvm_data;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   property p_nvm_first;
      $rose(rst_b) |-> ##[1:3] (nvm_rd && nvm_addr == 3'h0);
   endproperty
   a_nvm_first: assert property (p_nvm_first)
      else $error("first calibration read missing");
   property p_nvm_next;
      nvm_ack && nvm_addr != 3'h4 |=>
         nvm_rd && nvm_addr == $past(nvm_addr) + 3'h1;
   endproperty
   a_nvm_next: assert property (p_nvm_next)
      else $error("calibration words out of order");
   property p_nvm_pulse;
      nvm_rd |=> !nvm_rd;
   endproperty
   a_nvm_pulse: assert property (p_nvm_pulse)
      else $error("word read longer than a cycle");
   property p_quiet_nvm;
      nvm_rd |-> drv == 4'h0;
   endproperty
   a_quiet_nvm: assert property (p_quiet_nvm)
      else $error("outputs active before calibration check");
   property p_zero_dn;
      nvm_ack && nvm_addr == 3'h4 && nvm_data == sum_r && !selftest_in
         |-> ##[1:4] drv.dn;
   endproperty
   a_zero_dn: assert property (p_zero_dn)
      else $error("zeroing does not lower");
   property p_susp_off;
      nvm_ack && nvm_addr == 3'h4 && nvm_data != sum_r |=> (drv == 4'h0)[*8];
   endproperty
   a_susp_off: assert property (p_susp_off)
      else $error("outputs active with bad calibration");
   property p_relay_excl;
      !(drv.up && drv.dn);
   endproperty
   a_relay_excl: assert property (p_relay_excl)
      else $error("raise and lower together");
   property p_estop;
      (!estop_ok_in)[*7] |-> drv == 4'h0;
   endproperty
   a_estop: assert property (p_estop)
      else $error("outputs live with stop loop open");
   property p_ac;
      (!ac_ok_in)[*7] |-> drv == 4'h0;
   endproperty
   a_ac: assert property (p_ac)
      else $error("outputs live without AC");
   property p_mflt;
      mc_fault_in[*7] |-> !drv.belt_en;
   endproperty
   a_mflt: assert property (p_mflt)
      else $error("belt enabled during motor fault");
   c_lower: cover property (drv.dn);
   c_raise: cover property (drv.up);
   c_belt: cover property (drv.belt_en);
endmodule // bse_core_chk
`default_nettype wire

// file: test/bse_plant.sv
// Far side model: calibration memory, belt pulses and elevation gear
`timescale 1ns/10ps
`default_nettype none
module bse_plant import bse_pkg::*; (
   input wire logic mclk, // System clock
   input wire logic rst_b, // Reset, active low
   input wire logic nvm_rd, // Word read pulse
   input wire logic [2:0] nvm_addr, // Word index
   input wire logic bad_sum, // Corrupt stored checksum
   input wire logic slow, // Answer reads late
   input wire logic [15:0] spd_per, // Pulse period, zero stops
   input wire bse_drv_s drv, // Drive outputs of the core
   output logic [15:0] nvm_data, // Word
   output logic nvm_ack, // Word valid
   output logic reed, // Pulley pulses
   output logic mref, // Motor speed pulses
   output logic elev_sw, // Gear switch
   output var int pos // Gear position in switch counts
);
   logic [15:0] rom [5] = '{16'h0080, 16'h0200, 16'h0200, 16'h0008, 16'h0488};
   logic [2:0] a;
   int lat, pc, ec;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         nvm_ack <= 1'b0;
         nvm_data <= 16'h5a5a;
         lat <= 0;
         a <= 3'h0;
         pc <= 0;
         ec <= 0;
         elev_sw <= 1'b0;
         pos <= 3;
      end else begin
         nvm_ack <= 1'b0;
         nvm_data <= ~nvm_data; // Idle bus churns
         if (nvm_rd) begin
            a <= nvm_addr;
            lat <= slow ? 6 : 1;
         end else begin
            if (lat == 1) begin
               nvm_ack <= 1'b1;
               nvm_data <= rom[a] ^ {15'h0000, bad_sum && a == 3'h4};
            end
            if (lat > 0) lat <= lat - 1;
         end
         pc <= (drv.belt_en && spd_per != 0 && pc < spd_per - 1) ? pc + 1 : 0;
         ec <= (drv.up || (drv.dn && pos > 0)) ? ec + 1 : 0;
         if (ec == 19) begin
            elev_sw <= ~elev_sw;
            pos <= drv.up ? pos + 1 : pos - 1;
            ec <= 0;
         end
      end
   end
   assign reed = drv.belt_en && pc < spd_per / 2;
   assign mref = reed;
endmodule // bse_plant
`default_nettype wire

// file: test/belt_speed_elevation_control_tb_top.sv
// Self-checking bench of the belt speed and elevation control core
`timescale 1ns/10ps
`default_nettype none
module belt_speed_elevation_control_tb_top;
   import bse_pkg::*;
   localparam logic [15:0] W0 = 16'h0080;
   localparam logic [15:0] W3 = 16'h0008;
   logic mclk, rst_b, nvm_rd, nvm_ack, reed, mref, esw, estop, ac, mflt;
   logic bad_sum, slow, selft = 1'b0;
   logic [2:0] nvm_addr;
   logic [15:0] rdata, nvm_data, spd_per, d;
   logic [2:0] ba [3] = '{REG_SPD, REG_ELEV, REG_ELEV};
   logic [15:0] bv [3] = '{16'h0097, 16'h002b, 16'h0104};
   bse_req_s req;
   bse_drv_s drv;
   int pos, err_total, checks, x, i, n, v;
   bse_core #(.WIN(10_000), .ZERO(200), .TRIM(400), .COMM(100), .DEB(4))
   u_bse_core (.mclk(mclk), .rst_b(rst_b), .req(req), .rdata(rdata),
      .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_data(nvm_data),
      .nvm_ack(nvm_ack), .reed_in(reed), .mref_in(mref), .elev_sw_in(esw),
      .estop_ok_in(estop), .ac_ok_in(ac), .mc_fault_in(mflt),
      .selftest_in(selft), .drv(drv));
   bse_plant u_bse_plant (.mclk(mclk), .rst_b(rst_b), .nvm_rd(nvm_rd),
      .nvm_addr(nvm_addr), .bad_sum(bad_sum), .slow(slow), .spd_per(spd_per),
      .drv(drv), .nvm_data(nvm_data), .nvm_ack(nvm_ack), .reed(reed),
      .mref(mref), .elev_sw(esw), .pos(pos));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   function automatic int xs(input int s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [15:0] ex_duty(input int s);
      int t;
      t = (s * int'(W0)) >> 4;
      return (t > 1023) ? 16'h03ff : t[15:0];
   endfunction
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] w);
      @(posedge mclk);
      req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge mclk);
      req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wst(input logic [7:0] s);
      d = 'x;
      for (n = 0; n < 20000 && d[7:0] !== s; n++) rd(REG_STAT);
      cmp({8'h00, d[7:0]}, {8'h00, s});
   endtask
   task automatic boot(input logic bad, input logic sl);
      rst_b <= 1'b0;
      bad_sum <= bad;
      slow <= sl;
      spd_per <= 16'h0000;
      mflt <= 1'b0;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge mclk);
      err_total++;
      end_sim();
   end
   initial begin
      req = '0;
      estop = 1'b1;
      ac = 1'b1;
      x = 59745;
      boot(1'b0, 1'b0);
      wst(ST_ZERO);
      cmp({12'h000, drv}, 16'h0001);
      wst(ST_OPER);
      rd(REG_SPD);
      cmp(d, 16'h0000);
      rd(REG_ELEV);
      cmp(d, 16'h0000);
      $display("zeroing test over");
      for (i = 0; i < 3; i++) begin
         wr(ba[i], bv[i]);
         rd(REG_STAT);
         cmp({15'h0000, d[15]}, 16'h0001);
         rd(ba[i]);
         cmp(d, 16'h0000);
         rd(REG_STAT);
         cmp({15'h0000, d[15]}, 16'h0000);
      end
      for (i = 0; i < 7; i++) begin
         x = xs(x);
         v = (i == 6) ? 150 : 1 + (x & 32'h0000_7fff) % 150;
         wr(REG_SPD, v[15:0]);
         rd(REG_DUTY);
         cmp(d, ex_duty(v));
      end
      $display("set point test over");
      for (i = 0; i < 2; i++) begin
         v = (i == 0) ? 50 : 20;
         wr(REG_ELEV, v[15:0]);
         repeat (4) @(posedge mclk);
         for (n = 0; n < 9000 && (drv.up === 1'b1 || drv.dn === 1'b1); n++)
            @(posedge mclk);
         repeat (30) @(posedge mclk);
         v = (v * int'(W3)) >> 4;
         cmp(pos[15:0], v[15:0]);
         rd(REG_POS);
         cmp(d, v[15:0]);
      end
      $display("elevation test over");
      wr(REG_SPD, 16'h0028);
      wr(REG_CMD, 16'h0002);
      repeat (3) @(posedge mclk);
      cmp({15'h0000, drv.belt_en}, 16'h0001);
      n = 0;
      for (i = 0; i < 2500; i++) begin
         @(posedge mclk);
         #1 n += drv.pwm;
      end
      cmp(n[15:0], 16'((ex_duty(40) * 2500 + 1023) / 1024));
      spd_per <= 16'h0014;
      wst(ST_FAULT);
      rd(REG_STAT);
      cmp({12'h000, d[11:8]}, 16'h0001);
      cmp({15'h0000, drv.belt_en}, 16'h0000);
      $display("over-speed test over");
      for (i = 0; i < 2; i++) begin
         boot(1'b0, 1'b1);
         wst(ST_OPER);
         spd_per <= 16'h0032;
         wr(REG_SPD, 16'h0028);
         wr(REG_CMD, 16'h0002);
         repeat (3) @(posedge mclk);
         if (i == 0) estop <= 1'b0;
         else ac <= 1'b0;
         repeat (7) @(posedge mclk);
         #1 cmp({12'h000, drv}, 16'h0000);
         estop <= 1'b1;
         ac <= 1'b1;
      end
      boot(1'b0, 1'b0);
      wst(ST_OPER);
      wr(REG_CMD, 16'h0001);
      repeat (150) @(posedge mclk);
      cmp({12'h000, drv}, 16'h0000);
      mflt <= 1'b1;
      repeat (7) @(posedge mclk);
      rd(REG_STAT);
      cmp({4'h0, d[11:0]}, 16'h0880);
      $display("shutdown test over");
      boot(1'b0, 1'b0);
      wst(ST_ZERO);
      wr(REG_CMD, 16'h0001);
      wst(ST_NORESP);
      wst(ST_ZERO);
      selft <= 1'b1;
      wr(REG_CMD, 16'h0001);
      wst(ST_NORESP);
      wr(REG_CMD, 16'h0004);
      wst(ST_SELF);
      boot(1'b1, 1'b0);
      wst(ST_SUSP);
      wr(REG_SPD, 16'h0028);
      wr(REG_CMD, 16'h0002);
      repeat (3) @(posedge mclk);
      cmp({12'h000, drv}, 16'h0000);
      rd(REG_SPD);
      cmp(d, 16'h0000);
      $display("start-up mode test over");
      end_sim();
   end
endmodule // belt_speed_elevation_control_tb_top
bind bse_core bse_core_chk u_bse_core_chk (.mclk(mclk), .rst_b(rst_b),
   .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_data(nvm_data),
   .nvm_ack(nvm_ack), .estop_ok_in(estop_ok_in), .ac_ok_in(ac_ok_in),
   .mc_fault_in(mc_fault_in), .selftest_in(selftest_in), .drv(drv));
`default_nettype wire
